// *** core/eeprom_dev.sv ***
// Serial EEPROM device end: instruction decode, status word, protection, hold.
//
// Behaviour
// - Active only while selected and not held.
// - Sample on rising, shift out after falling.
// - First bit at first rise after select.
// - Output floats while bits shift in.
// - Reads drive every fall, ignore input.
// - Everything moves most significant bit first.
// - Eight-bit instruction register, six operations.
// - Decode set, clear, status read and write, array read and write.
// - Protect pin low refuses all writes.
// - Programming already begun completes regardless.
// - Latch clear blocks; protect bits guard blocks.
// - Status: level bits 3:2, latch 1, busy 0.
// - Hold entered only while clock low.
// - Suspended: ignore clock and input, float.
// - Release resumes only while clock low.
// - Hold low always floats the output.
// - Master ties hold high when unused.
// - Clock idle low or high both work.
// - Level codes protect none, C0, 80, all.
// - Powers up with write latch clear.
// - While busy only status read accepted.
// - Unknown opcode: ignore until next select.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module eeprom_dev (
	input wire logic mclk,
	input wire logic rst_b,
	eeprom_link_if.device link,
	output logic busy_ff,
	output logic [7:0] status_ff
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] meta_ff; // First stage for sel, sck, sdi, hold, wp.
	logic [4:0] sync_ff; // Second stage, the only stage logic reads.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= 5'h1f;
			sync_ff <= 5'h1f;
		end else begin
			meta_ff <= {link.sel_b, link.sck, link.sdi, link.hold_b, link.wp_b};
			sync_ff <= meta_ff;
		end
	end
	logic sel_b, sck, sdi, hold_b, wp_b; // Synchronised pin levels.
	assign {sel_b, sck, sdi, hold_b, wp_b} = sync_ff;
	logic sck_d_ff; // Previous clock level for edge finding.
	logic sel_d_ff; // Previous select level.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sck_d_ff <= 1'b1; // Matches the synchroniser's reset level, so no false edge.
			sel_d_ff <= 1'b1;
		end else begin
			sck_d_ff <= sck;
			sel_d_ff <= sel_b;
		end
	end
	logic rise, fall, sel_start, sel_end; // Edge events.
	assign rise = sck && !sck_d_ff;
	assign fall = !sck && sck_d_ff;
	assign sel_start = !sel_b && sel_d_ff;
	assign sel_end = sel_b && !sel_d_ff;
	// ----------------------------------------
	// Hold tracking
	// ----------------------------------------
	logic held_ff; // Set while the transfer is suspended.
	// Hold changes state only while the clock is low, or at a falling edge; deselect clears it at any clock level.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			held_ff <= 1'b0;
		end else if (sel_b) begin
			held_ff <= 1'b0;
		end else if (!sck || fall) begin
			held_ff <= !hold_b;
		end
	end
	logic active; // Link is live for shifting.
	assign active = !sel_b && !held_ff;
	// ----------------------------------------
	// Serial transfer state
	// ----------------------------------------
	logic [7:0] shift_ff; // Incoming byte shift register.
	logic [2:0] bitcnt_ff; // Bit index within the current byte.
	logic [7:0] instr_ff; // Latched instruction.
	logic [1:0] phase_ff; // 0 opcode, 1 address or status data, 2 data, 3 dead.
	logic [7:0] addr_ff; // Array address.
	logic outmode_ff; // Set once a read starts outputting.
	logic [7:0] out_ff; // Outgoing byte shift register.
	logic [7:0] mem_ff [4][64]; // Array storage, one bank per page slot (low address bits).
	logic [2:0] obit_ff; // Output bit count.
	logic [7:0] page_ff [4]; // Page data buffer.
	logic [3:0] pvalid_ff; // Page slots loaded.
	logic [1:0] pl_ff; // Protect level bits.
	logic wl_ff; // Write-enable latch.
	logic pend_st_ff; // Status write pending select release.
	logic pend_arr_ff; // Array write pending select release.
	logic [7:0] pend_st_val_ff; // Status data to commit.
	logic [31:0] prog_cnt_ff; // Programming countdown.
	logic prog_st_ff; // Programming targets the status word.
	logic [7:0] byte_in; // Byte completed on this rise.
	assign byte_in = {shift_ff[6:0], sdi};
	logic byte_done; // Last bit of a byte captured now.
	assign byte_done = active && rise && !outmode_ff && bitcnt_ff == eeprom_link_pkg::BIT_LAST;
	// Protection decision for an address by level.
	function automatic logic guarded(input logic [1:0] pl, input logic [7:0] a);
		guarded = (pl == eeprom_link_pkg::PL_NONE) ? 1'b0 :
			(pl == eeprom_link_pkg::PL_QTR) ? (a >= eeprom_link_pkg::QTR_BASE) :
			(pl == eeprom_link_pkg::PL_HALF) ? (a >= eeprom_link_pkg::HALF_BASE) : 1'b1;
	endfunction
	// Shift input bits on rising edges, starting fresh at each select.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			shift_ff <= 8'h00;
			bitcnt_ff <= 3'h0;
		end else if (sel_start || sel_b) begin
			bitcnt_ff <= 3'h0;
		end else if (active && rise && !outmode_ff && phase_ff != 2'h3) begin
			shift_ff <= byte_in;
			bitcnt_ff <= bitcnt_ff + 3'h1;
		end
	end
	// Sequence through opcode, address and data bytes.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			instr_ff <= 8'h00;
			phase_ff <= 2'h0;
			addr_ff <= 8'h00;
			outmode_ff <= 1'b0;
			pend_st_ff <= 1'b0;
			pend_arr_ff <= 1'b0;
			pend_st_val_ff <= 8'h00;
			pvalid_ff <= 4'h0;
		end else if (sel_start || sel_b) begin
			phase_ff <= 2'h0;
			outmode_ff <= 1'b0;
			if (sel_b) begin
				pend_st_ff <= 1'b0;
				pend_arr_ff <= 1'b0;
				pvalid_ff <= 4'h0;
			end
		end else if (byte_done && phase_ff == 2'h0) begin
			instr_ff <= byte_in;
			// While busy only status read goes on; unknown codes go dead.
			if (busy_ff && byte_in != eeprom_link_pkg::OP_RD_STAT) begin
				phase_ff <= 2'h3;
			end else if (byte_in == eeprom_link_pkg::OP_RD_STAT) begin
				outmode_ff <= 1'b1;
			end else if (byte_in == eeprom_link_pkg::OP_RD_ARR ||
				byte_in == eeprom_link_pkg::OP_WR_ARR || byte_in == eeprom_link_pkg::OP_WR_STAT) begin
				phase_ff <= 2'h1;
			end else begin
				phase_ff <= 2'h3; // Set and clear latch need nothing more.
			end
		end else if (byte_done && phase_ff == 2'h1) begin
			if (instr_ff == eeprom_link_pkg::OP_WR_STAT) begin
				pend_st_val_ff <= byte_in;
				pend_st_ff <= 1'b1;
				phase_ff <= 2'h3;
			end else begin
				addr_ff <= byte_in;
				phase_ff <= 2'h2;
				outmode_ff <= (instr_ff == eeprom_link_pkg::OP_RD_ARR);
			end
		end else if (byte_done && phase_ff == 2'h2) begin
			// Page write: low two address bits wrap within the page.
			page_ff[addr_ff[1:0]] <= byte_in;
			pvalid_ff[addr_ff[1:0]] <= 1'b1;
			addr_ff <= {addr_ff[7:2], addr_ff[1:0] + 2'h1};
			pend_arr_ff <= 1'b1;
		end else if (outmode_ff && active && fall && obit_ff == 3'h0 &&
			instr_ff == eeprom_link_pkg::OP_RD_ARR) begin
			addr_ff <= addr_ff + 8'h01; // Once per byte loaded; sequential read rolls over.
		end
	end
	// Output shifter: load on the fall after the last input bit and on every eighth fall after it, shift on the others.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			out_ff <= 8'h00;
			obit_ff <= 3'h0;
		end else if (!outmode_ff) begin
			obit_ff <= 3'h0;
		end else if (active && fall) begin
			if (obit_ff == 3'h0) begin
				out_ff <= (instr_ff == eeprom_link_pkg::OP_RD_STAT) ? status_ff :
					mem_ff[addr_ff[1:0]][addr_ff[7:2]];
			end else begin
				out_ff <= {out_ff[6:0], 1'b0};
			end
			obit_ff <= obit_ff + 3'h1;
		end
	end
	logic out_live_ff; // Set after the first output fall.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			out_live_ff <= 1'b0;
		end else if (!outmode_ff) begin
			out_live_ff <= 1'b0;
		end else if (active && fall) begin
			out_live_ff <= 1'b1;
		end
	end
	// Drive only while outputting and not held; float otherwise.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link.sdo_oe <= 1'b0;
			link.sdo_o <= 1'b0;
		end else begin
			link.sdo_oe <= out_live_ff && !sel_b && hold_b && !held_ff;
			link.sdo_o <= out_ff[7];
		end
	end
	// ----------------------------------------
	// Write latch, protection and programming
	// ----------------------------------------
	logic start_st, start_arr; // Programming launched at select release.
	// Writes need the latch set and protect pin high; array needs an open block.
	assign start_st = sel_end && pend_st_ff && wl_ff && wp_b && !busy_ff;
	assign start_arr = sel_end && pend_arr_ff && wl_ff && wp_b && !busy_ff &&
		!guarded(pl_ff, addr_ff);
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wl_ff <= 1'b0;
		end else if (start_st || start_arr) begin
			wl_ff <= 1'b0; // Auto-disable after a write.
		end else if (byte_done && phase_ff == 2'h0 && !busy_ff) begin
			if (byte_in == eeprom_link_pkg::OP_SET_WL) begin
				wl_ff <= 1'b1;
			end else if (byte_in == eeprom_link_pkg::OP_CLR_WL) begin
				wl_ff <= 1'b0;
			end
		end
	end
	// Programming runs to the end once begun, whatever the protect pin does.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busy_ff <= 1'b0;
			prog_cnt_ff <= 32'h0;
			prog_st_ff <= 1'b0;
			pl_ff <= 2'h0;
		end else if (start_st || start_arr) begin
			busy_ff <= 1'b1;
			prog_st_ff <= start_st;
			prog_cnt_ff <= 32'(eeprom_link_pkg::PROG_CYC);
		end else if (busy_ff) begin
			if (prog_cnt_ff == 32'h1) begin
				busy_ff <= 1'b0;
				if (prog_st_ff) begin
					pl_ff <= pend_st_val_ff[eeprom_link_pkg::ST_PL_HI:eeprom_link_pkg::ST_PL_LO];
				end
			end
			prog_cnt_ff <= prog_cnt_ff - 32'h1;
		end
	end
	// Array commit on completion, one page slot per generated lane.
	logic [7:0] prog_addr_ff; // Page base held during programming.
	logic [3:0] prog_valid_ff; // Slots to commit.
	logic [7:0] prog_data_ff [4]; // Data held during programming.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prog_addr_ff <= 8'h00;
			prog_valid_ff <= 4'h0;
		end else if (start_arr) begin
			prog_addr_ff <= addr_ff;
			prog_valid_ff <= pvalid_ff;
		end
	end
	for (genvar g = 0; g < 4; g++) begin : g_page
		always_ff @(posedge mclk) begin
			if (start_arr) begin
				prog_data_ff[g] <= page_ff[g];
			end
			if (busy_ff && !prog_st_ff && prog_cnt_ff == 32'h1 && prog_valid_ff[g]) begin
				mem_ff[g][prog_addr_ff[7:2]] <= prog_data_ff[g];
			end
		end
	end
	// Status word as read back; upper bits read zero.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			status_ff <= 8'h00;
		end else begin
			status_ff <= {4'h0, pl_ff, wl_ff, busy_ff};
		end
	end
endmodule

// *** core/eeprom_host.sv ***
// Serial master end: runs one transaction per request and returns read data.
`timescale 1ns/1ps
module eeprom_host (
	input wire logic mclk,
	input wire logic rst_b,
	eeprom_link_if.host link,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata_ff
);
	// ----------------------------------------
	// Registers: 0 go+len, 1 tx bytes, 2 rx byte, 3 pins
	// ----------------------------------------
	logic [7:0] tx_ff [4]; // Bytes to send, MSB first.
	logic [1:0] txi_ff; // Next tx slot written by software.
	logic [2:0] len_ff; // Total bytes in the frame.
	logic [7:0] rx_ff; // Last byte received.
	logic hold_req_ff, wp_req_ff; // Pin controls from software.
	logic start_ff; // Go pulse.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			txi_ff <= 2'h0;
			len_ff <= 3'h0;
			start_ff <= 1'b0;
			hold_req_ff <= 1'b1; // Hold idles high when unused.
			wp_req_ff <= 1'b1;
		end else begin
			start_ff <= 1'b0;
			if (wr && addr == 2'h0) begin
				len_ff <= wdata[2:0];
				start_ff <= 1'b1;
				txi_ff <= 2'h0;
			end else if (wr && addr == 2'h1) begin
				tx_ff[txi_ff] <= wdata;
				txi_ff <= txi_ff + 2'h1;
			end else if (wr && addr == 2'h3) begin
				hold_req_ff <= wdata[0];
				wp_req_ff <= wdata[1];
			end
		end
	end
	// ----------------------------------------
	// Sequencer: mode 0, sample-in on device rise
	// ----------------------------------------
	eeprom_link_pkg::host_state_t st_ff;
	logic [7:0] div_ff; // Half period divider.
	logic [5:0] bits_ff; // Bits remaining.
	logic [7:0] sh_ff; // Outgoing byte.
	logic [2:0] bi_ff; // Byte index.
	logic so_m_ff, so_s_ff; // Output synchroniser.
	logic busy_ff; // Frame in progress.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			so_m_ff <= 1'b0;
			so_s_ff <= 1'b0;
		end else begin
			so_m_ff <= link.sdo;
			so_s_ff <= so_m_ff;
		end
	end
	// Drive clock idle low, change data while low, capture while high.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= eeprom_link_pkg::H_IDLE;
			div_ff <= 8'h00;
			bits_ff <= 6'h0;
			bi_ff <= 3'h0;
			sh_ff <= 8'h00;
			rx_ff <= 8'h00;
			busy_ff <= 1'b0;
			link.sel_b <= 1'b1;
			link.sck <= 1'b0;
			link.sdi <= 1'b0;
		end else if (div_ff != 8'h00) begin
			div_ff <= div_ff - 8'h01;
		end else begin
			case (st_ff)
				eeprom_link_pkg::H_IDLE: begin
					if (start_ff && len_ff != 3'h0) begin
						link.sel_b <= 1'b0;
						sh_ff <= tx_ff[0];
						bi_ff <= 3'h1;
						bits_ff <= 6'({len_ff, 3'h0});
						busy_ff <= 1'b1;
						div_ff <= eeprom_link_pkg::HALF_SCK_CNT;
						st_ff <= eeprom_link_pkg::H_LEAD;
					end
				end
				eeprom_link_pkg::H_LEAD: begin
					link.sdi <= sh_ff[7];
					div_ff <= eeprom_link_pkg::HALF_SCK_CNT;
					st_ff <= eeprom_link_pkg::H_LOW;
				end
				eeprom_link_pkg::H_LOW: begin
					// A suspended frame waits here, clock low, and resumes on the same bit.
					if (link.hold_b) begin
						link.sck <= 1'b1;
						div_ff <= eeprom_link_pkg::HALF_SCK_CNT;
						st_ff <= eeprom_link_pkg::H_HIGH;
					end
				end
				eeprom_link_pkg::H_HIGH: begin
					// Hold and release are changed only around the low phase.
					link.sck <= 1'b0;
					rx_ff <= {rx_ff[6:0], so_s_ff};
					bits_ff <= bits_ff - 6'h1;
					div_ff <= eeprom_link_pkg::HALF_SCK_CNT;
					if (bits_ff == 6'h1) begin
						st_ff <= eeprom_link_pkg::H_TAIL;
					end else begin
						if (bits_ff[2:0] == 3'h1) begin
							sh_ff <= (bi_ff < 3'h4) ? tx_ff[bi_ff[1:0]] : 8'h00;
							link.sdi <= (bi_ff < 3'h4) ? tx_ff[bi_ff[1:0]][7] : 1'b0;
							bi_ff <= bi_ff + 3'h1;
						end else begin
							sh_ff <= {sh_ff[6:0], 1'b0};
							link.sdi <= sh_ff[6];
						end
						st_ff <= eeprom_link_pkg::H_LOW;
					end
				end
				default: begin
					link.sel_b <= 1'b1;
					busy_ff <= 1'b0;
					st_ff <= eeprom_link_pkg::H_IDLE;
				end
			endcase
		end
	end
	// Hold pin may only change while the clock is low; the master keeps select.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			link.hold_b <= 1'b1;
			link.wp_b <= 1'b1;
		end else begin
			link.wp_b <= wp_req_ff;
			// Hold never drops on the edge that raises the clock, so no bit is cut.
			if (!link.sck && (hold_req_ff || st_ff != eeprom_link_pkg::H_LOW ||
				div_ff != 8'h00)) begin
				link.hold_b <= hold_req_ff;
			end
		end
	end
	// Register read port, data one cycle after the strobe.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 8'h00;
		end else if (rd) begin
			if (addr == 2'h0) begin
				rdata_ff <= {7'h00, busy_ff};
			end else if (addr == 2'h2) begin
				rdata_ff <= rx_ff;
			end else if (addr == 2'h3) begin
				rdata_ff <= {6'h00, wp_req_ff, hold_req_ff};
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end
endmodule

// *** core/eeprom_link_if.sv ***
// Wire bundle joining the serial master and the EEPROM device.
`timescale 1ns/1ps
interface eeprom_link_if;
	logic sel_b; // Active-low select from the master.
	logic sck; // Serial clock from the master.
	logic sdi; // Serial data toward the device.
	logic hold_b; // Active-low suspend from the master.
	logic wp_b; // Active-low write protect from the master.
	logic sdo_o; // Device output value.
	logic sdo_oe; // Device output enable, high while driving.
	wire sdo = sdo_oe ? sdo_o : 1'b1; // Resolved output; reads high while released.
	modport device (input sel_b, sck, sdi, hold_b, wp_b, output sdo_o, sdo_oe);
	modport host (output sel_b, sck, sdi, hold_b, wp_b, input sdo);
endinterface

// *** core/eeprom_link_pkg.sv ***
// Shared constants for the serial EEPROM link: opcodes, status layout, timing.
package eeprom_link_pkg;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_SET_WL = 8'h06; // Set write-enable latch.
	localparam logic [7:0] OP_CLR_WL = 8'h04; // Clear write-enable latch.
	localparam logic [7:0] OP_RD_STAT = 8'h05; // Read status word.
	localparam logic [7:0] OP_WR_STAT = 8'h01; // Write status word.
	localparam logic [7:0] OP_RD_ARR = 8'h03; // Read memory array.
	localparam logic [7:0] OP_WR_ARR = 8'h02; // Write memory array.
	// ----------------------------------------
	// Status word layout
	// ----------------------------------------
	localparam int ST_BUSY = 0; // Busy flag position.
	localparam int ST_WL = 1; // Write-enable latch position.
	localparam int ST_PL_LO = 2; // Protect level low bit.
	localparam int ST_PL_HI = 3; // Protect level high bit.
	localparam logic [1:0] PL_NONE = 2'h0; // Nothing protected.
	localparam logic [1:0] PL_QTR = 2'h1; // Top quarter protected.
	localparam logic [1:0] PL_HALF = 2'h2; // Top half protected.
	localparam logic [7:0] QTR_BASE = 8'hc0; // First address of top quarter.
	localparam logic [7:0] HALF_BASE = 8'h80; // First address of top half.
	localparam logic [2:0] BIT_LAST = 3'h7; // Index of the last bit of a byte.
	localparam logic [1:0] PAGE_MASK = 2'h3; // Page offset counter width marker.
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int MCLK_NS = 50; // System clock period in ns.
	localparam int PROG_US = 100; // Programming time in microseconds (bench-scaled).
	localparam int PROG_CYC = (PROG_US * 1000 + MCLK_NS - 1) / MCLK_NS; // Cycles of programming.
	localparam int HALF_SCK_NS = 500; // Half period of the host serial clock.
	localparam int HALF_SCK_CYC = (HALF_SCK_NS + MCLK_NS - 1) / MCLK_NS; // Cycles per half.
	localparam logic [7:0] HALF_SCK_CNT = 8'(HALF_SCK_CYC - 1); // Divider reload value.
	// Host sequencer states, Gray-coded along the usual path except the step from H_TAIL back to H_IDLE.
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_LEAD = 3'b001,
		H_LOW = 3'b011,
		H_HIGH = 3'b010,
		H_TAIL = 3'b110
	} host_state_t;
endpackage

// *** sim/eeprom_link_monitor.sv ***
// Concurrent checks on the serial link between the master and the EEPROM device.
`timescale 1ns/1ps
module eeprom_link_monitor (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic sel_b,
	input wire logic sck,
	input wire logic sdi,
	input wire logic hold_b,
	input wire logic wp_b,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic busy_ff,
	input wire logic [7:0] status_ff
);
	localparam int PROG_LO = eeprom_link_pkg::PROG_CYC - 2; // Shortest accepted programming.
	localparam int PROG_HI = eeprom_link_pkg::PROG_CYC + 2; // Longest accepted programming.
	logic [15:0] busy_cnt_ff; // Cycles spent busy in the current programming run.

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Counts busy cycles so the length of a programming run can be judged when it ends.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busy_cnt_ff <= 16'h0000;
		end else if (busy_ff) begin
			busy_cnt_ff <= busy_cnt_ff + 16'h0001;
		end else begin
			busy_cnt_ff <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence deselected_s; // Select has been high long enough to pass the synchronisers.
		sel_b [*6];
	endsequence
	sequence held_s; // Suspend has been low long enough to pass the synchronisers.
		!hold_b [*6];
	endsequence
	sequence prog_start_s; // A programming run begins.
		$rose(busy_ff);
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	deselect_float_a: assert property (deselected_s |-> !sdo_oe)
		else $error("device drives the output while deselected");
	out_after_fall_a: assert property ($changed(sdo_o) && sdo_oe && $past(sdo_oe) |-> !sck)
		else $error("output changed while the serial clock was high");
	in_while_low_a: assert property ($changed(sdi) && !sel_b |-> !sck)
		else $error("serial input changed while the serial clock was high");
	idle_clock_low_a: assert property ($fell(sel_b) |-> !sck)
		else $error("serial clock not idle low at select");
	status_layout_a: assert property (status_ff[7:4] == 4'h0 &&
		status_ff[0] == $past(busy_ff))
		else $error("status word layout broken");
	latch_autoclear_a: assert property (prog_start_s |-> ##[0:4] !status_ff[1])
		else $error("write latch not cleared when programming started");
	prog_guard_a: assert property (prog_start_s |-> sel_b &&
		$past(status_ff[1], 2) && $past(wp_b, 4))
		else $error("programming started without latch, protect pin or deselect");
	level_change_a: assert property ($changed(status_ff[3:2]) |->
		!busy_ff && $past(busy_ff, 2))
		else $error("protect level changed outside programming");
	prog_length_a: assert property ($fell(busy_ff) |->
		busy_cnt_ff >= PROG_LO && busy_cnt_ff <= PROG_HI)
		else $error("programming run has the wrong length");
	hold_float_a: assert property (held_s |-> !sdo_oe)
		else $error("device drives the output while suspended");
endmodule

// *** sim/serial_eeprom_interface_tb.sv ***
// Self-checking bench: master and EEPROM joined over the link, driven through the register port.
`timescale 1ns/1ps
module serial_eeprom_interface_tb;
	logic mclk; // System clock.
	logic rst_b; // Asynchronous reset, active low.
	logic [1:0] addr; // Register address toward the master.
	logic [7:0] wdata; // Register write data.
	logic wr; // Register write strobe.
	logic rd; // Register read strobe.
	logic [7:0] rdata_ff; // Register read data.
	logic busy_ff; // Device programming flag.
	logic [7:0] status_ff; // Device status word.
	logic [7:0] st; // Scratch received byte.
	logic drove; // Set when the device drove its output during a frame.
	int n_errors; // Mismatches found.
	int checked; // Comparisons made.

	eeprom_link_if link ();
	eeprom_host eeprom_host_i (.mclk(mclk), .rst_b(rst_b), .link(link), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata_ff(rdata_ff));
	eeprom_dev eeprom_dev_i (.mclk(mclk), .rst_b(rst_b), .link(link), .busy_ff(busy_ff),
		.status_ff(status_ff));
	eeprom_link_monitor eeprom_link_monitor_i (.mclk(mclk), .rst_b(rst_b), .sel_b(link.sel_b),
		.sck(link.sck), .sdi(link.sdi), .hold_b(link.hold_b), .wp_b(link.wp_b),
		.sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .busy_ff(busy_ff), .status_ff(status_ff));

	// Free-running 20 MHz system clock.
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task stop_test();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Compares a seen value with the expected one.
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle register write.
	task wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// One-cycle register read; the data stand in the following cycle.
	task rd_reg(input logic [1:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		d = rdata_ff;
	endtask
	// Polls the master until its frame ends, noting whether the device drove the output.
	task wait_idle(output logic oe);
		logic [7:0] r;
		oe = 1'b0;
		for (int i = 0; i < 1000; i++) begin
			if (link.sdo_oe === 1'b1) oe = 1'b1;
			rd_reg(2'h0, r);
			if (r[0] === 1'b0) return;
		end
		n_errors++;
		$display("unexpected at %0t: master frame never ended", $time);
		stop_test();
	endtask
	// Sends up to three bytes in one frame and returns the last byte received.
	task frame(input logic [7:0] b0, b1, b2, n, output logic [7:0] rx, output logic oe);
		wr_reg(2'h1, b0);
		wr_reg(2'h1, b1);
		wr_reg(2'h1, b2);
		wr_reg(2'h0, n);
		wait_idle(oe);
		rd_reg(2'h2, rx);
	endtask
	// Waits for the device busy flag to reach a level, bounded.
	task wait_prog(input logic want);
		for (int i = 0; i < 3000 && busy_ff !== want; i++) @(posedge mclk);
		if (busy_ff !== want) begin
			n_errors++;
			$display("unexpected at %0t: busy flag stuck", $time);
			stop_test();
		end
	endtask
	// Single-byte instruction.
	task cmd(input logic [7:0] op);
		logic [7:0] r;
		frame(op, 8'h00, 8'h00, 8'h01, r, drove);
	endtask
	// Status read returning the status byte.
	task rd_stat(output logic [7:0] s);
		frame(eeprom_link_pkg::OP_RD_STAT, 8'h00, 8'h00, 8'h02, s, drove);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Latch set and clear, with the output idle for writes and driven for reads.
	task s_latch();
		chk(status_ff, 8'h00);
		chk({7'h0, link.sel_b}, 8'h01);
		cmd(eeprom_link_pkg::OP_SET_WL);
		chk({7'h0, drove}, 8'h00);
		rd_stat(st);
		chk(st, 8'h02);
		chk({7'h0, drove}, 8'h01);
		cmd(eeprom_link_pkg::OP_CLR_WL);
		rd_stat(st);
		chk(st, 8'h00);
	endtask
	// Status write refused while the protect pin is low.
	task s_wp();
		cmd(eeprom_link_pkg::OP_SET_WL);
		wr_reg(2'h3, 8'h01); // Protect low, hold high.
		frame(eeprom_link_pkg::OP_WR_STAT, 8'h0c, 8'h00, 8'h02, st, drove);
		repeat (20) @(posedge mclk);
		chk({7'h0, busy_ff}, 8'h00);
		rd_stat(st);
		chk(st & 8'h0c, 8'h00);
		wr_reg(2'h3, 8'h03);
	endtask
	// Status write sets level 01; status reads still answer while busy.
	task s_level();
		cmd(eeprom_link_pkg::OP_SET_WL);
		frame(eeprom_link_pkg::OP_WR_STAT, 8'h04, 8'h00, 8'h02, st, drove);
		wait_prog(1'b1);
		wr_reg(2'h3, 8'h01); // Protect drops while programming runs.
		rd_stat(st);
		chk({7'h0, st[0]}, 8'h01);
		wait_prog(1'b0);
		wr_reg(2'h3, 8'h03);
		rd_stat(st);
		chk(st, 8'h04);
	endtask
	// Array write below the protected quarter succeeds, inside it is refused.
	task s_array();
		cmd(eeprom_link_pkg::OP_SET_WL);
		frame(eeprom_link_pkg::OP_WR_ARR, 8'h10, 8'ha5, 8'h03, st, drove);
		wait_prog(1'b1);
		wait_prog(1'b0);
		frame(eeprom_link_pkg::OP_RD_ARR, 8'h10, 8'h00, 8'h03, st, drove);
		chk(st, 8'ha5);
		cmd(eeprom_link_pkg::OP_SET_WL);
		frame(eeprom_link_pkg::OP_WR_ARR, 8'hc0, 8'h5a, 8'h03, st, drove);
		repeat (40) @(posedge mclk);
		chk({7'h0, busy_ff}, 8'h00);
		cmd(eeprom_link_pkg::OP_CLR_WL);
	endtask
	// Unknown opcode keeps the output floating; the next frame works normally.
	task s_bad();
		frame(8'hff, 8'h00, 8'h00, 8'h02, st, drove);
		chk({7'h0, drove}, 8'h00);
		rd_stat(st);
		chk(st, 8'h04);
	endtask
	// Suspend in mid-read floats the output; the read then resumes intact.
	task s_hold();
		wr_reg(2'h1, eeprom_link_pkg::OP_RD_STAT);
		wr_reg(2'h1, 8'h00);
		wr_reg(2'h0, 8'h02);
		repeat (240) @(posedge mclk); // Well into the output byte.
		wr_reg(2'h3, 8'h02); // Hold low, protect high.
		repeat (30) @(posedge mclk);
		chk({7'h0, link.sdo_oe}, 8'h00);
		wr_reg(2'h3, 8'h03);
		wait_idle(drove);
		rd_reg(2'h2, st);
		chk(st, 8'h04);
		chk(status_ff, 8'h04);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		n_errors = 0;
		checked = 0;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		s_latch();
		s_wp();
		s_level();
		s_array();
		s_bad();
		s_hold();
		stop_test();
	end
endmodule
